// ===== pdt_pkg.sv
package pdt_pkg;

   // Register select codes on the byte-wide register port.
   localparam logic [4:0] ADDR_CONTROL    = 5'h10;
   localparam logic [4:0] ADDR_VECTOR     = 5'h11;
   localparam logic [4:0] ADDR_PRE_NULL   = 5'h12;
   localparam logic [4:0] ADDR_PRE_HIGH   = 5'h13;
   localparam logic [4:0] ADDR_PRE_MID    = 5'h14;
   localparam logic [4:0] ADDR_PRE_LOW    = 5'h15;
   localparam logic [4:0] ADDR_CNT_NULL   = 5'h16;
   localparam logic [4:0] ADDR_CNT_HIGH   = 5'h17;
   localparam logic [4:0] ADDR_CNT_MID    = 5'h18;
   localparam logic [4:0] ADDR_CNT_LOW    = 5'h19;
   localparam logic [4:0] ADDR_STATUS     = 5'h1A;

   // Widths, reset values and bit positions.
   localparam int         COUNT_W         = 24;
   localparam int         PRESCALE_W      = 5;
   localparam logic [7:0] VECTOR_RESET    = 8'h0F;
   localparam logic [7:0] CONTROL_RESET   = 8'h00;
   localparam logic [4:0] PRESCALE_HALT   = 5'h1F;
   localparam int         STATUS_ZD_BIT   = 0;
   localparam int         CONTROL_SPARE   = 3;

   // Clock path select encodings.
   localparam logic [1:0] CLK_SYS         = 2'h0;
   localparam logic [1:0] CLK_SYS_GATED   = 2'h1;
   localparam logic [1:0] CLK_EXT_PRE     = 2'h2;
   localparam logic [1:0] CLK_EXT_DIRECT  = 2'h3;

   // Output pin function encodings.
   localparam logic [2:0] PIN_IRQ_OFF_ACK = 3'h4;
   localparam logic [2:0] PIN_IRQ_VECTOR  = 3'h5;
   localparam logic [2:0] PIN_IRQ_OFF     = 3'h6;
   localparam logic [2:0] PIN_IRQ_AUTO    = 3'h7;

   // Control register layout, bit 7 down to bit 0.
   typedef struct packed {
      logic [2:0] pin_mode;
      logic       zd_roll;
      logic       spare;
      logic [1:0] clk_sel;
      logic       enable;
   } pdt_control_type;

   // One register port request, valid for one cycle while strobe is high.
   typedef struct packed {
      logic       strobe;
      logic       write;
      logic [4:0] addr;
      logic [7:0] wdata;
   } pdt_bus_req_type;

   // Loaded/counting phase of the run state.
   typedef enum logic [0:0] {
      PH_WAIT_LOAD = 1'b0,
      PH_COUNTING  = 1'b1
   } pdt_phase_type;

endpackage

// ===== pdt_edge_detect.sv
`timescale 1ns/10ps
module pdt_edge_detect (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_level,
   output logic      o_rise
);
   import pdt_pkg::*;

   logic prev_reg;

   // Previous sample of the input; a rising step gives one pulse.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= i_level;
      end
   end

   assign o_rise = i_level & ~prev_reg;

   a_rise_single: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_rise |=> !o_rise) else $error("edge pulse lasted more than one cycle");

endmodule // pdt_edge_detect

// ===== pdt_prescaler.sv
`timescale 1ns/10ps
module pdt_prescaler #(
   parameter int PRE_W = pdt_pkg::PRESCALE_W
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_run,
   input  wire logic i_tick,
   output logic      o_wrap
);
   import pdt_pkg::*;

   logic [PRE_W-1:0] count_reg;

   // Forced to all ones in halt so every run starts a full divide-by-32 period.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_reg <= PRE_W'(PRESCALE_HALT);
      end else if (!i_run) begin
         count_reg <= PRE_W'(PRESCALE_HALT);
      end else if (i_tick) begin
         count_reg <= count_reg - PRE_W'(1);
      end
   end

   // Wrap from zero to all ones clocks the main counter.
   assign o_wrap = i_run & i_tick & (count_reg == '0);

   a_pre_halt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_run |=> count_reg == PRE_W'(PRESCALE_HALT)) else $error("prescaler not forced in halt");

   a_pre_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_run && !i_tick && $past(i_run) |=> $stable(count_reg)) else $error("prescaler moved without tick");

endmodule // pdt_prescaler

// ===== pdt_timer.sv
// Behaviour
// - Vector register returned on normal reads and on interrupt acknowledge; always accessible.
// - Preload held as three addressable bytes, also reachable by multi-byte moves.
// - Reset leaves the preload bytes unchanged.
// - Count bytes read the live counter unlatched; writes complete and are dropped.
// - Byte below count high reads zero and ignores writes.
// - Zero-detect flag sets when the counter steps from one to zero.
// - Status reads are harmless; writing bit 0 clears; halt clears the flag.
// - Reset clears the whole control register, halting the timer.
// - In halt counter holds, prescaler forced to 0x1F, flag forced clear.
// - In run counter uses the selected source; prescaler moves only if used.
// - 24-bit counter fed by divide-by-32 prescaler or external input directly.
// - First prescaler wrap after run loads preload; later wraps count.
// - Without prescaler, first external edge loads preload; later edges count.
// - Preload access never waits for, nor is guarded against, counter transfers.
// - Zero-detect control clear reloads on next counter clock; set rolls over.
// - Gated mode runs only while enabled and external input high.
// - Vectored mode drives output pin low while flag set; acknowledge input used.
// - Acknowledge answered with vector only while request asserted in vectored mode.
`timescale 1ns/10ps
module pdt_timer #(
   parameter int CNT_W = pdt_pkg::COUNT_W
) (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst_n,
   input  wire pdt_pkg::pdt_bus_req_type i_bus_req,
   output logic [7:0]                   o_bus_rdata,
   output logic                         o_bus_dtack,
   input  wire logic                    i_timer_irq_acknowledge,
   input  wire logic                    i_external_timer_input,
   output logic                         o_timer_output_pin,
   output logic                         o_timer_output_pin_oe
);
   import pdt_pkg::*;

   pdt_control_type  control_reg;
   logic [7:0]       timer_vector_reg;
   logic [CNT_W-1:0] preload_reg;
   logic [CNT_W-1:0] counter_reg;
   logic [CNT_W-1:0] counter_next;
   pdt_phase_type    phase_reg;
   logic             zero_detect_flag_reg;
   logic             square_reg;
   logic             timer_output_pin_next;
   logic             timer_output_pin_oe_next;
   logic             run;
   logic             ext_rise;
   logic             pre_tick;
   logic             pre_wrap;
   logic             cnt_tick;
   logic             zd_event;
   logic             wr_strobe;
   logic             ack_answer;
   logic             count_known_reg;

   // Byte lane k of a 24-bit value, k = 2 for high down to 0 for low.
   function automatic logic [7:0] byte_of(input logic [CNT_W-1:0] value, input int k);
      byte_of = value[k*8 +: 8];
   endfunction

   // Read multiplexer; null bytes, the spare control bit and unused status bits read zero.
   function automatic logic [7:0] read_mux(input logic [4:0] addr);
      logic [7:0] r;
      r = 8'h00;
      unique case (addr)
         ADDR_CONTROL:  begin r = control_reg; r[CONTROL_SPARE] = 1'b0; end
         ADDR_VECTOR:   r = timer_vector_reg;
         ADDR_PRE_HIGH: r = byte_of(preload_reg, 2);
         ADDR_PRE_MID:  r = byte_of(preload_reg, 1);
         ADDR_PRE_LOW:  r = byte_of(preload_reg, 0);
         ADDR_CNT_HIGH: r = byte_of(counter_reg, 2);
         ADDR_CNT_MID:  r = byte_of(counter_reg, 1);
         ADDR_CNT_LOW:  r = byte_of(counter_reg, 0);
         ADDR_STATUS:   r[STATUS_ZD_BIT] = zero_detect_flag_reg;
         default:       r = 8'h00;
      endcase
      return r;
   endfunction

   assign wr_strobe = i_bus_req.strobe & i_bus_req.write;

   // Gated mode uses the external input as a run qualifier instead of a clock.
   assign run = control_reg.enable &
                ((control_reg.clk_sel != CLK_SYS_GATED) | i_external_timer_input);

   pdt_edge_detect u_ext_edge (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_level   (i_external_timer_input),
      .o_rise    (ext_rise)
   );

   // Prescaler is clocked every system cycle or by external rising edges.
   assign pre_tick = (control_reg.clk_sel == CLK_EXT_PRE) ? ext_rise : 1'b1;

   pdt_prescaler #(
      .PRE_W (PRESCALE_W)
   ) u_prescaler (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_run     (run & (control_reg.clk_sel != CLK_EXT_DIRECT)),
      .i_tick    (pre_tick),
      .o_wrap    (pre_wrap)
   );

   // Counter clock; the source must stay at or below one eighth of the system rate.
   assign cnt_tick = run & ((control_reg.clk_sel == CLK_EXT_DIRECT) ? ext_rise : pre_wrap);

   // Zero detect happens only on a real decrement from one, not on a load.
   assign zd_event = cnt_tick & (phase_reg == PH_COUNTING) & (counter_reg == CNT_W'(1));

   // Control register: cleared by reset like flags and phase, vector reset to 0x0F; preload and counter are not.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         control_reg <= CONTROL_RESET;
      end else if (wr_strobe && i_bus_req.addr == ADDR_CONTROL) begin
         control_reg <= i_bus_req.wdata;
      end
   end

   // Vector register, writable at any time.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_vector_reg <= VECTOR_RESET;
      end else if (wr_strobe && i_bus_req.addr == ADDR_VECTOR) begin
         timer_vector_reg <= i_bus_req.wdata;
      end
   end

   // Preload bytes carry no reset so a reset never loses the programmed period.
   // Writes land at once even if a transfer to the counter happens this cycle.
   always_ff @(posedge i_ref_clk) begin
      if (wr_strobe) begin
         unique case (i_bus_req.addr)
            ADDR_PRE_HIGH: preload_reg[23:16] <= i_bus_req.wdata;
            ADDR_PRE_MID:  preload_reg[15:8]  <= i_bus_req.wdata;
            ADDR_PRE_LOW:  preload_reg[7:0]   <= i_bus_req.wdata;
            default:       preload_reg        <= preload_reg;
         endcase
      end
   end

   // Next counter value: first tick loads, zero either reloads or rolls over.
   always_comb begin
      counter_next = counter_reg;
      if (cnt_tick) begin
         if (phase_reg == PH_WAIT_LOAD) begin
            counter_next = preload_reg;
         end else if (counter_reg == '0 && !control_reg.zd_roll) begin
            counter_next = preload_reg;
         end else begin
            counter_next = counter_reg - CNT_W'(1);
         end
      end
   end

   // Counter has no reset and simply holds while halted; count writes are dropped.
   always_ff @(posedge i_ref_clk) begin
      counter_reg <= counter_next;
   end

   // The counter powers up unknown, so halt checks only start once a load has given it a value.
   // Reset clears this marker as a precaution even though the counter keeps its contents.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_known_reg <= 1'b0;
      end else if (cnt_tick) begin
         count_known_reg <= 1'b1;
      end
   end

   // Phase returns to waiting-for-load every time the timer halts.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_reg <= PH_WAIT_LOAD;
      end else if (!run) begin
         phase_reg <= PH_WAIT_LOAD;
      end else if (cnt_tick) begin
         phase_reg <= PH_COUNTING;
      end
   end

   // Zero-detect flag: halt forces clear; a new detect beats a software clear.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         zero_detect_flag_reg <= 1'b0;
      end else if (!run) begin
         zero_detect_flag_reg <= 1'b0;
      end else if (zd_event) begin
         zero_detect_flag_reg <= 1'b1;
      end else if (wr_strobe && i_bus_req.addr == ADDR_STATUS && i_bus_req.wdata[STATUS_ZD_BIT]) begin
         zero_detect_flag_reg <= 1'b0;
      end
   end

   // Square wave level, high in halt and toggled on each zero detect.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         square_reg <= 1'b1;
      end else if (!run) begin
         square_reg <= 1'b1;
      end else if (zd_event) begin
         square_reg <= ~square_reg;
      end
   end

   // Output pin function; interrupt request is open drain, low while flagged.
   always_comb begin
      timer_output_pin_next    = 1'b1;
      timer_output_pin_oe_next = 1'b0;
      unique case (control_reg.pin_mode)
         3'h2, 3'h3: begin
            timer_output_pin_oe_next = 1'b1;
            timer_output_pin_next    = square_reg;
         end
         PIN_IRQ_VECTOR, PIN_IRQ_AUTO: begin
            timer_output_pin_oe_next = zero_detect_flag_reg;
            timer_output_pin_next    = 1'b0;
         end
         default: begin
            timer_output_pin_oe_next = 1'b0;
            timer_output_pin_next    = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_timer_output_pin    <= 1'b1;
         o_timer_output_pin_oe <= 1'b0;
      end else begin
         o_timer_output_pin    <= timer_output_pin_next;
         o_timer_output_pin_oe <= timer_output_pin_oe_next;
      end
   end

   // Acknowledge is honoured only in vectored mode with the request asserted.
   assign ack_answer = i_timer_irq_acknowledge & (control_reg.pin_mode == PIN_IRQ_VECTOR) &
                       zero_detect_flag_reg;

   // Bus answer one cycle after the request; a register access wins over an acknowledge.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bus_dtack <= 1'b0;
         o_bus_rdata <= 8'h00;
      end else if (i_bus_req.strobe) begin
         o_bus_dtack <= 1'b1;
         o_bus_rdata <= i_bus_req.write ? 8'h00 : read_mux(i_bus_req.addr);
      end else if (ack_answer) begin
         o_bus_dtack <= 1'b1;
         o_bus_rdata <= timer_vector_reg;
      end else begin
         o_bus_dtack <= 1'b0;
         o_bus_rdata <= 8'h00;
      end
   end

   a_zd_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      zd_event |=> zero_detect_flag_reg) else $error("zero detect flag not set");

   a_zd_halt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !run |=> !zero_detect_flag_reg) else $error("flag survived halt");

   a_halt_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      count_known_reg && !run |=> counter_reg == $past(counter_reg)) else $error("counter moved in halt");

   a_first_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      cnt_tick && phase_reg == PH_WAIT_LOAD |=> counter_reg == $past(preload_reg))
      else $error("first tick did not load preload");

   a_zero_reload: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      cnt_tick && phase_reg == PH_COUNTING && counter_reg == '0 && !control_reg.zd_roll
      |=> counter_reg == $past(preload_reg)) else $error("no reload after zero");

   a_zero_roll: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      cnt_tick && phase_reg == PH_COUNTING && counter_reg == '0 && control_reg.zd_roll
      |=> &counter_reg) else $error("no roll over after zero");

   a_ack_vector: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ack_answer && !i_bus_req.strobe |=> o_bus_dtack && o_bus_rdata == $past(timer_vector_reg))
      else $error("acknowledge not answered with vector");

   a_ack_silent: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_timer_irq_acknowledge && !i_bus_req.strobe &&
      (control_reg.pin_mode != PIN_IRQ_VECTOR || !zero_detect_flag_reg)
      |=> !o_bus_dtack) else $error("acknowledge answered outside vectored mode");

   a_null_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_bus_req.strobe && !i_bus_req.write &&
      (i_bus_req.addr == ADDR_PRE_NULL || i_bus_req.addr == ADDR_CNT_NULL)
      |=> o_bus_dtack && o_bus_rdata == 8'h00) else $error("null byte not zero");

   a_gate_halt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      control_reg.clk_sel == CLK_SYS_GATED && !i_external_timer_input
      |=> !zero_detect_flag_reg && phase_reg == PH_WAIT_LOAD) else $error("gated mode ran with input low");

   a_irq_pin: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      control_reg.pin_mode == PIN_IRQ_VECTOR && zero_detect_flag_reg
      |=> o_timer_output_pin_oe && !o_timer_output_pin) else $error("request pin not low");

   a_square_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      zd_event |=> square_reg != $past(square_reg)) else $error("square wave did not toggle");

endmodule // pdt_timer

// ===== pdt_host_model.sv
`timescale 1ns/10ps
// Host processor model that makes one register access at a time on the strobe port.
module pdt_host_model (
   input  wire logic                   i_ref_clk,
   output pdt_pkg::pdt_bus_req_type    o_bus_req,
   input  wire logic [7:0]             i_bus_rdata,
   input  wire logic                   i_bus_dtack
);
   import pdt_pkg::*;

   // The bus starts idle so nothing is taken before the first access.
   initial begin
      o_bus_req = '0;
   end

   // Strobe stands for one cycle; the answer is collected in the cycle after the taking edge.
   // Released write data is inverted so a stale byte can never pass for a fresh one.
   task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic ok);
      @(negedge i_ref_clk);
      o_bus_req = '{strobe: 1'b1, write: wr, addr: a, wdata: d};
      @(negedge i_ref_clk);
      o_bus_req.strobe = 1'b0;
      o_bus_req.wdata  = ~d;
      ok = i_bus_dtack;
      q  = i_bus_rdata;
   endtask
endmodule // pdt_host_model

// ===== tb_pdt_timer.sv
`timescale 1ns/10ps
module tb_pdt_timer;
   import pdt_pkg::*;
   logic            ref_clk = 1'b0;
   logic            rst_n   = 1'b0;
   logic            ack     = 1'b0;
   logic            ext     = 1'b0;
   pdt_bus_req_type bus_req;
   logic [7:0]      rdata;
   logic            dtack;
   logic            pin;
   logic            pin_oe;
   int              num_errors  = 0;
   int              check_count = 0;
   int              seed        = 32'h5a37b017;
   logic [7:0]      q;
   logic            ok;
   logic [7:0]      vec;
   logic [23:0]     pre;
   logic [23:0]     cnt_exp [5] = '{24'h2, 24'h1, 24'h0, 24'h2, 24'h1};

   // Free-running 125 MHz reference clock.
   always #4 ref_clk = ~ref_clk;

   pdt_timer u_pdt_timer (
      .i_ref_clk               (ref_clk),
      .i_rst_n                 (rst_n),
      .i_bus_req               (bus_req),
      .o_bus_rdata             (rdata),
      .o_bus_dtack             (dtack),
      .i_timer_irq_acknowledge (ack),
      .i_external_timer_input  (ext),
      .o_timer_output_pin      (pin),
      .o_timer_output_pin_oe   (pin_oe)
   );

   pdt_host_model u_pdt_host_model (
      .i_ref_clk   (ref_clk),
      .o_bus_req   (bus_req),
      .i_bus_rdata (rdata),
      .i_bus_dtack (dtack)
   );

   // Compare one byte and report at once.
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Byte i of a 24-bit value, with byte 2 the high byte.
   function automatic logic [7:0] byte_of(input logic [23:0] v, input int i);
      return v[8*i +: 8];
   endfunction

   // Register accesses; every access must be answered whatever the address.
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      u_pdt_host_model.access(1'b1, a, d, q, ok);
      check("write dtack", {7'h00, ok}, 8'h01);
   endtask

   task automatic rd(input logic [4:0] a);
      u_pdt_host_model.access(1'b0, a, 8'h00, q, ok);
      check("read dtack", {7'h00, ok}, 8'h01);
   endtask

   task automatic wr_pre(input logic [23:0] v);
      for (int b = 0; b < 3; b++) begin
         wr(ADDR_PRE_HIGH + 5'(b), byte_of(v, 2 - b));
      end
   endtask

   // Edges are spaced eight cycles apart so the counter rate stays legal.
   task automatic ext_pulse();
      @(negedge ref_clk);
      ext = 1'b1;
      repeat (4) @(negedge ref_clk);
      ext = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask

   // Poll the status byte for the zero-detect flag with a bounded count.
   task automatic wait_flag();
      for (int n = 0; n < 300; n++) begin
         rd(ADDR_STATUS);
         if (q[0] === 1'b1) break;
      end
   endtask

   task automatic results();
      $display("Checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog sized well beyond the 1250 or so cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      results();
   end

   // Main sequence.
   initial begin
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      rd(ADDR_VECTOR);
      check("vector reset", q, VECTOR_RESET);
      rd(ADDR_CONTROL);
      check("control reset", q, CONTROL_RESET);
      // Random register traffic, with writes aimed at the read-only places as well.
      for (int i = 0; i < 8; i++) begin
         vec = 8'($random(seed));
         pre = 24'($random(seed));
         if (pre == 24'h0) pre = 24'h1;
         wr(ADDR_VECTOR, vec);
         wr(ADDR_PRE_NULL, ~vec);
         wr(ADDR_CNT_NULL, vec);
         wr_pre(pre);
         rd(ADDR_VECTOR);
         check("vector", q, vec);
         for (int b = 0; b < 3; b++) begin
            rd(ADDR_PRE_HIGH + 5'(b));
            check("preload byte", q, byte_of(pre, 2 - b));
         end
         rd(ADDR_PRE_NULL);
         check("preload null", q, 8'h00);
         rd(ADDR_CNT_NULL);
         check("count null", q, 8'h00);
         rd(5'h1F);
         check("unmapped", q, 8'h00);
      end
      // Direct external edges: first edge loads, later edges count and reload after zero.
      wr_pre(24'h2);
      wr(ADDR_CONTROL, 8'h07);
      for (int k = 0; k < 5; k++) begin
         ext_pulse();
         if (k == 0) wr(ADDR_CNT_LOW, 8'hFF);
         for (int b = 0; b < 3; b++) begin
            rd(ADDR_CNT_HIGH + 5'(b));
            check("count byte", q, byte_of(cnt_exp[k], 2 - b));
         end
         rd(ADDR_STATUS);
         if (k == 1) check("flag before zero", q, 8'h00);
         if (k == 2) check("flag at zero", q, 8'h01);
      end
      // Halting clears the flag and freezes the counter against further edges.
      wr(ADDR_CONTROL, 8'h06);
      rd(ADDR_STATUS);
      check("flag after halt", q, 8'h00);
      ext_pulse();
      rd(ADDR_CNT_LOW);
      check("count in halt", q, 8'h01);
      // Prescaled system clock with roll-over on zero.
      wr_pre(24'h3);
      wr(ADDR_CONTROL, 8'h11);
      wait_flag();
      check("flag prescaled", q, 8'h01);
      rd(ADDR_CNT_LOW);
      check("count at zero", q, 8'h00);
      wr(ADDR_STATUS, 8'h01);
      rd(ADDR_STATUS);
      check("flag cleared", q, 8'h00);
      repeat (40) @(negedge ref_clk);
      rd(ADDR_CNT_HIGH);
      check("rolled count", q, 8'hFF);
      wr(ADDR_CONTROL, 8'h00);
      // Vectored interrupt: pin pulled low while flagged, acknowledge answered only then.
      wr_pre(24'h1);
      wr(ADDR_CONTROL, 8'hA1);
      wait_flag();
      check("pin enable", {7'h00, pin_oe}, 8'h01);
      check("pin level", {7'h00, pin}, 8'h00);
      @(negedge ref_clk);
      ack = 1'b1;
      @(negedge ref_clk);
      ack = 1'b0;
      check("ack dtack", {7'h00, dtack}, 8'h01);
      check("ack vector", rdata, vec);
      wr(ADDR_STATUS, 8'h01);
      @(negedge ref_clk);
      check("pin released", {7'h00, pin_oe}, 8'h00);
      ack = 1'b1;
      @(negedge ref_clk);
      ack = 1'b0;
      check("ack refused", {7'h00, dtack}, 8'h00);
      // Input edges into the prescaler, autovector pin: the 64th edge gives the first zero detect.
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, 8'hE5);
      repeat (63) ext_pulse();
      rd(ADDR_STATUS);
      check("flag after 63 edges", q, 8'h00);
      ext_pulse();
      rd(ADDR_STATUS);
      check("flag after 64 edges", q, 8'h01);
      check("autovector pin enable", {7'h00, pin_oe}, 8'h01);
      @(negedge ref_clk);
      ack = 1'b1;
      @(negedge ref_clk);
      ack = 1'b0;
      check("ack in autovector", {7'h00, dtack}, 8'h00);
      // Gated system clock with square wave pin: a low input halts, a high input runs.
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, 8'h43);
      repeat (40) @(negedge ref_clk);
      rd(ADDR_CNT_LOW);
      check("gated count held", q, 8'h00);
      check("square oe in halt", {7'h00, pin_oe}, 8'h01);
      check("square level in halt", {7'h00, pin}, 8'h01);
      ext = 1'b1;
      wait_flag();
      check("gated flag", q, 8'h01);
      check("square toggled", {7'h00, pin}, 8'h00);
      @(negedge ref_clk);
      ack = 1'b1;
      @(negedge ref_clk);
      ack = 1'b0;
      check("ack in square mode", {7'h00, dtack}, 8'h00);
      ext = 1'b0;
      rd(ADDR_STATUS);
      check("gated halt flag", q, 8'h00);
      check("square level back", {7'h00, pin}, 8'h01);
      // A reset while gated mode is halted by a low input keeps the preload but restores control and vector.
      @(negedge ref_clk);
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      rd(ADDR_PRE_LOW);
      check("preload kept", q, 8'h01);
      rd(ADDR_VECTOR);
      check("vector again", q, VECTOR_RESET);
      rd(ADDR_CONTROL);
      check("control again", q, CONTROL_RESET);
      results();
   end
endmodule // tb_pdt_timer
